// ==== ptc_params.svh ====
// Purpose: Constants for the periodic timer capture block
// Assumes: 100 MHz clock, byte-wide register port
// Notes:   Offsets are byte addresses on the plain register port
`ifndef PTC_PARAMS_SVH
`define PTC_PARAMS_SVH
`define PTC_CNT_W        10
`define PTC_ADDR_W       4
`define PTC_OFF_CTRL0    4'h0
`define PTC_OFF_CTRL1    4'h1
`define PTC_OFF_CMPA_L   4'h2
`define PTC_OFF_CMPA_H   4'h3
`define PTC_OFF_CMPP_L   4'h4
`define PTC_OFF_CMPP_H   4'h5
`define PTC_OFF_CNT_L    4'h6
`define PTC_OFF_CNT_H    4'h7
`define PTC_OFF_STATUS   4'h8
`define PTC_OFF_IRQ_EN   4'h9
`define PTC_OFF_IRQ_CLR  4'hA
`define PTC_MODE_CMP     2'h0
`define PTC_MODE_CAP     2'h1
`define PTC_MODE_PWM     2'h2
`define PTC_IO_RISE      2'h0
`define PTC_IO_FALL      2'h1
`define PTC_IO_BOTH      2'h2
`define PTC_IO_NONE      2'h3
`define PTC_BIT_RUN      3
`define PTC_BIT_CAPTS    0
`define PTC_BIT_CCLR     1
`define PTC_BIT_OC       2
`define PTC_BIT_POL      3
`define PTC_ST_CAP       0
`define PTC_ST_PMATCH    1
`define PTC_ST_AMATCH    2
`define PTC_CNT_MAX      10'h3FF
`endif

// ==== ptc_pkg.sv ====
// Purpose: Types for the periodic timer capture block
// Assumes: Constants come from ptc_params.svh
// Notes:   State enum of the counter controller
package ptc_pkg;
   typedef enum logic [1:0] {PTC_IDLE, PTC_RUN} ptc_state_e;
endpackage

// ==== ptc_edge_det.sv ====
// Purpose: Synchronise one input and flag qualifying edges
// Assumes: Input asynchronous to clock
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ns
`include "ptc_params.svh"
module ptc_edge_det
   import ptc_pkg::*;
(
   input  wire logic       clock,     // System clock
   input  wire logic       rst,       // Sync reset, high
   input  wire logic       din,       // Raw pin level
   input  wire logic [1:0] edge_sel,  // Edge selection
   output logic            edge_hit   // One-cycle qualifying edge
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic hit;
   } ptc_sync_s;

   ptc_sync_s st;
   ptc_sync_s next_st;

   // Next-state: shift samples, compare s2 and s3
   always_comb begin
      logic rise;
      logic fall;
      rise = 1'b0;
      fall = 1'b0;
      next_st = st;
      next_st.s1 = din;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      rise = st.s2 & ~st.s3;
      fall = ~st.s2 & st.s3;
      case (edge_sel)
         `PTC_IO_RISE: next_st.hit = rise;
         `PTC_IO_FALL: next_st.hit = fall;
         `PTC_IO_BOTH: next_st.hit = rise | fall;
         default:      next_st.hit = 1'b0;
      endcase
   end

   // State register
   always_ff @(posedge clock) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign edge_hit = st.hit;
endmodule

// ==== ptc_timer.sv ====
// Purpose: 10-bit periodic timer with capture and single pulse
// Assumes: Byte register port, read data one cycle after strobe
// Notes:   Compare-output and PWM waveforms are not produced here
`timescale 1ns/1ns
`include "ptc_params.svh"
module ptc_timer
   import ptc_pkg::*;
#(
   parameter int CNT_W = `PTC_CNT_W   // Counter width
)(
   input  wire logic                   clock,         // System clock
   input  wire logic                   rst,           // Sync reset, high
   input  wire logic [`PTC_ADDR_W-1:0] addr,          // Register address
   input  wire logic [7:0]             wdata,         // Write data
   input  wire logic                   wr,            // Write strobe
   input  wire logic                   rd,            // Read strobe
   output logic      [7:0]             rdata,         // Read data, next cycle
   input  wire logic                   cap_pin,       // Capture input pin
   input  wire logic                   ext_clk_pin,   // External timer clock pin
   output logic                        pulse_out,     // Single pulse output
   output logic                        irq            // Level interrupt
);
   typedef struct packed {
      ptc_state_e       state;
      logic             run;
      logic [1:0]       mode;
      logic [1:0]       pin_ctl;
      logic [3:0]       ctl1;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] cmp_a;
      logic [CNT_W-1:0] cmp_p;
      logic [7:0]       cmp_a_lo;
      logic [7:0]       cmp_p_lo;
      logic [2:0]       status;
      logic [2:0]       irq_en;
      logic             pulse;
      logic [7:0]       rdata;
   } ptc_reg_s;

   ptc_reg_s r;
   ptc_reg_s next_r;
   logic     cap_src;
   logic     cap_hit;
   logic     clk_hit;
   logic     cap_mode;
   logic     pulse_mode;

   // Pick low or high byte of a counter-wide value
   function automatic logic [7:0] byte_of(input logic [CNT_W-1:0] v, input logic hi);
      logic [15:0] w;
      w = 16'(v);
      return hi ? w[15:8] : w[7:0];
   endfunction

   // Join a high byte with a held low byte
   function automatic logic [CNT_W-1:0] join_of(input logic [7:0] hi, input logic [7:0] lo);
      return CNT_W'({hi, lo});
   endfunction

   assign cap_mode   = (r.mode == `PTC_MODE_CAP);
   assign pulse_mode = (r.mode == `PTC_MODE_PWM) && (r.pin_ctl == `PTC_IO_NONE);
   assign cap_src    = r.ctl1[`PTC_BIT_CAPTS] ? ext_clk_pin : cap_pin;

   // Synchronised edge detect; pin direction not consulted
   ptc_edge_det u_cap (
      .clock    (clock),
      .rst      (rst),
      .din      (cap_src),
      .edge_sel (r.pin_ctl),
      .edge_hit (cap_hit)
   );

   // Rising edge of the external clock pin for pulse triggering
   ptc_edge_det u_trig (
      .clock    (clock),
      .rst      (rst),
      .din      (ext_clk_pin),
      .edge_sel (`PTC_IO_RISE),
      .edge_hit (clk_hit)
   );

   // Next-state of the whole block
   always_comb begin
      logic             p_match;
      logic             a_match;
      logic [CNT_W-1:0] p_top;
      logic [2:0]       ev;
      p_match = 1'b0;
      a_match = 1'b0;
      p_top   = '0;
      ev      = '0;
      next_r  = r;
      next_r.rdata = 8'h00;

      // Register writes
      if (wr) begin
         case (addr)
            `PTC_OFF_CTRL0: begin
               next_r.run = wdata[`PTC_BIT_RUN];
            end
            `PTC_OFF_CTRL1: begin
               next_r.mode    = wdata[7:6];
               next_r.pin_ctl = wdata[5:4];
               next_r.ctl1    = wdata[3:0];
            end
            `PTC_OFF_CMPA_L: next_r.cmp_a_lo = wdata;
            `PTC_OFF_CMPA_H: next_r.cmp_a = join_of(wdata, r.cmp_a_lo);
            `PTC_OFF_CMPP_L: next_r.cmp_p_lo = wdata;
            `PTC_OFF_CMPP_H: next_r.cmp_p = join_of(wdata, r.cmp_p_lo);
            `PTC_OFF_IRQ_EN: next_r.irq_en = wdata[2:0];
            `PTC_OFF_IRQ_CLR: next_r.status = r.status & ~wdata[2:0];
            default: ;
         endcase
      end

      // Pin edge sets run bit in pulse mode
      if (pulse_mode && clk_hit) begin
         next_r.run = 1'b1;
      end

      // Compare-P of zero means full range
      p_top = (r.cmp_p == '0) ? CNT_W'(`PTC_CNT_MAX) : r.cmp_p;

      case (r.state)
         PTC_IDLE: begin
            // Run rising edge restarts from zero
            if (r.run) begin
               next_r.state = PTC_RUN;
               next_r.cnt   = '0;
               next_r.pulse = pulse_mode;
            end
         end
         PTC_RUN: begin
            if (!r.run) begin
               next_r.state = PTC_IDLE;
               next_r.pulse = 1'b0;
            end else begin
               p_match = cap_mode && (r.cnt == p_top);
               a_match = pulse_mode && (r.cnt == r.cmp_a);
               next_r.cnt = p_match ? '0 : r.cnt + 1'b1;
               if (a_match) begin
                  next_r.run   = 1'b0;
                  next_r.state = PTC_IDLE;
                  next_r.pulse = 1'b0;
               end
            end
         end
         default: next_r.state = PTC_IDLE;
      endcase

      // Capture into A; edge_det gives none for 11
      if (cap_mode && cap_hit) begin
         next_r.cmp_a = r.cnt;
      end
      // Capture mode leaves the output low
      if (!pulse_mode) begin
         next_r.pulse = 1'b0;
      end

      // Events set sticky bits, set wins over clear
      ev[`PTC_ST_CAP]    = cap_mode && cap_hit;
      ev[`PTC_ST_PMATCH] = p_match;
      ev[`PTC_ST_AMATCH] = a_match;
      next_r.status = next_r.status | ev;

      // Read data, one cycle later
      if (rd) begin
         case (addr)
            `PTC_OFF_CTRL0:  next_r.rdata = {4'h0, r.run, 3'h0};
            `PTC_OFF_CTRL1:  next_r.rdata = {r.mode, r.pin_ctl, r.ctl1};
            `PTC_OFF_CMPA_L: next_r.rdata = byte_of(r.cmp_a, 1'b0);
            `PTC_OFF_CMPA_H: next_r.rdata = byte_of(r.cmp_a, 1'b1);
            `PTC_OFF_CMPP_L: next_r.rdata = byte_of(r.cmp_p, 1'b0);
            `PTC_OFF_CMPP_H: next_r.rdata = byte_of(r.cmp_p, 1'b1);
            `PTC_OFF_CNT_L:  next_r.rdata = byte_of(r.cnt, 1'b0);
            `PTC_OFF_CNT_H:  next_r.rdata = byte_of(r.cnt, 1'b1);
            `PTC_OFF_STATUS: next_r.rdata = {5'h00, r.status};
            `PTC_OFF_IRQ_EN: next_r.rdata = {5'h00, r.irq_en};
            default:         next_r.rdata = 8'h00;
         endcase
      end
   end

   // State register
   always_ff @(posedge clock) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign rdata     = r.rdata;
   assign pulse_out = r.pulse;
   assign irq       = |(r.status & r.irq_en);
endmodule

// ==== ptc_monitor.sv ====
// Purpose: Port checker for the periodic timer capture block
// Assumes: Sees only the top module ports
// Notes:   Shadows control and enable writes
`timescale 1ns/1ns
module ptc_monitor (
   input wire logic       clock,       // Clock
   input wire logic       rst,         // Sync reset
   input wire logic [3:0] addr,        // Address
   input wire logic [7:0] wdata,       // Write data
   input wire logic       wr,          // Write strobe
   input wire logic       rd,          // Read strobe
   input wire logic [7:0] rdata,       // Read data
   input wire logic       cap_pin,     // Capture pin
   input wire logic       ext_clk_pin, // Timer clock pin
   input wire logic       pulse_out,   // Pulse output
   input wire logic       irq          // Interrupt
);
   logic [7:0] ctl;
   logic [7:0] ien;
   wire        pmode = ctl[7:4] == 4'hB;
   wire        cmode = ctl[7:6] == 2'h1;
   // Shadow of the control register
   always_ff @(posedge clock) begin
      if (rst) ctl <= 8'h00;
      else if (wr && addr == 4'h1) ctl <= wdata;
   end
   // Shadow of the interrupt enable
   always_ff @(posedge clock) begin
      if (rst) ien <= 8'h00;
      else if (wr && addr == 4'h9) ien <= wdata;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_run_on;
      pmode && wr && addr == 4'h0 && wdata[3];
   endsequence
   sequence s_pin_rise;
      pmode && $rose(ext_clk_pin);
   endsequence
   a_read_idle: assert property (!rd |=> rdata == 8'h00)
      else $error("read data not idle");
   a_unmapped_read: assert property (rd && addr > 4'hA |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_high_bytes: assert property (rd && addr inside {4'h3, 4'h5, 4'h7} |=> rdata[7:2] == 6'h00)
      else $error("high byte wider than ten bits");
   a_irq_masked: assert property (ien[2:0] == 3'h0 |-> !irq)
      else $error("interrupt while masked");
   a_cap_no_out: assert property (cmode [*2] |-> !pulse_out)
      else $error("output driven in capture mode");
   a_sw_start: assert property (s_run_on |-> ##[1:3] pulse_out)
      else $error("pulse not started by run bit");
   a_sw_stop: assert property (wr && addr == 4'h0 && !wdata[3] |-> ##2 !pulse_out)
      else $error("pulse not ended by run clear");
   a_pin_start: assert property (s_pin_rise |-> ##[1:8] pulse_out)
      else $error("pulse not started by pin edge");
endmodule

// ==== ptc_pin_src.sv ====
// Purpose: External pulse source on a capture pin
// Assumes: One request gives one pulse of W cycles
// Notes:   Line idles low between pulses
`timescale 1ns/1ns
module ptc_pin_src #(
   parameter int W = 30 // Pulse length in cycles
)(
   input  wire logic clock, // Clock
   input  wire logic go,    // Pulse request
   output logic      pin    // Pulse line
);
   int left = 0;
   initial pin = 1'b0;
   // Count down the high time after each request
   always @(posedge clock) begin
      left <= go ? W : (left > 0 ? left - 1 : 0);
      pin <= go || left > 1;
   end
endmodule

// ==== tb.sv ====
// Purpose: Self-checking bench for the periodic timer capture block
// Assumes: Byte register port, read data one cycle after strobe
// Notes:   Pulse source feeds either pin by use_ext
`timescale 1ns/1ns
module tb;
   logic       clock, rst, wr, rd, go, use_ext, pin, pulse_out, irq;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, v, ca;
   int         failures, comparisons, cyc;
   ptc_timer i_ptc_timer (.clock, .rst, .addr, .wdata, .wr, .rd, .rdata,
      .cap_pin(pin & ~use_ext), .ext_clk_pin(pin & use_ext), .pulse_out, .irq);
   ptc_pin_src i_ptc_pin_src (.clock, .go, .pin);
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Compare and count
   task automatic chk(input string n, input logic [9:0] s, e);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   // Bus write and read cycles
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      v = rdata;
   endtask
   task automatic fire;
      @(posedge clock);
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
   endtask
   task automatic results;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic t_regs;
      rreg(4'hF);
      chk("unmapped", v, 10'h000);
      wreg(4'h2, 8'h5A);
      wreg(4'h3, 8'hFF);
      rreg(4'h3);
      chk("cmp a high", v, 10'h003);
      $display("test regs done");
   endtask
   task automatic t_cap;
      logic er, ef;
      wreg(4'h9, 8'h01);
      wreg(4'h0, 8'h08);
      for (int k = 0; k < 8; k++) begin
         er = k[1:0] != 2'h1 && k[1:0] != 2'h3;
         ef = k[1:0] == 2'h1 || k[1:0] == 2'h2;
         use_ext <= k[2];
         wreg(4'h1, {2'h1, k[1:0], 3'h7, k[2]});
         wreg(4'hA, 8'hFF);
         fire;
         repeat (10) @(negedge clock);
         rreg(4'h8);
         chk("rise cap", v[0], er);
         chk("rise irq", irq, er);
         chk("no out", pulse_out, 1'b0);
         rreg(4'h2);
         ca = v;
         rreg(4'h6);
         if (er) chk("cap age", v - ca < 8'd24, 1'b1);
         wreg(4'hA, 8'hFF);
         repeat (30) @(negedge clock);
         rreg(4'h8);
         chk("fall cap", v[0], ef);
      end
      $display("test capture done");
   endtask
   task automatic t_wrap;
      wreg(4'h0, 8'h00);
      wreg(4'h9, 8'h02);
      wreg(4'hA, 8'hFF);
      wreg(4'h0, 8'h08);
      repeat (1000) @(negedge clock);
      rreg(4'h8);
      chk("no wrap", v[1], 1'b0);
      repeat (40) @(negedge clock);
      chk("full wrap", irq, 1'b1);
      wreg(4'h4, 8'h14);
      wreg(4'h5, 8'h00);
      wreg(4'h0, 8'h00);
      wreg(4'hA, 8'hFF);
      wreg(4'h0, 8'h08);
      for (int k = 0; k < 12; k++) begin
         rreg(4'h6);
         chk("cnt max", v <= 8'h14, 1'b1);
      end
      chk("p irq", irq, 1'b1);
      $display("test wrap done");
   endtask
   task automatic t_pulse;
      wreg(4'h0, 8'h00);
      wreg(4'h1, 8'hB0);
      wreg(4'h2, 8'h40);
      wreg(4'h3, 8'h00);
      wreg(4'h9, 8'h04);
      wreg(4'hA, 8'hFF);
      use_ext <= 1'b1;
      fire;
      repeat (10) @(negedge clock);
      chk("pin start", pulse_out, 1'b1);
      repeat (80) @(negedge clock);
      chk("a end", pulse_out, 1'b0);
      chk("a irq", irq, 1'b1);
      rreg(4'h0);
      chk("run clear", v[3], 1'b0);
      wreg(4'h0, 8'h08);
      repeat (4) @(negedge clock);
      chk("sw start", pulse_out, 1'b1);
      wreg(4'h0, 8'h00);
      repeat (4) @(negedge clock);
      chk("sw stop", pulse_out, 1'b0);
      $display("test pulse done");
   endtask
   // Cycle ceiling against hangs
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         failures++;
         results;
      end
   end
   // Reset, then run the scenarios
   initial begin
      rst = 1'b1;
      {wr, rd, go, use_ext, addr, wdata} = '0;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      t_regs;
      t_cap;
      t_wrap;
      t_pulse;
      results;
   end
endmodule
bind ptc_timer ptc_monitor i_ptc_monitor (.clock, .rst, .addr, .wdata, .wr, .rd, .rdata,
   .cap_pin, .ext_clk_pin, .pulse_out, .irq);
